// [rtl/ppi_map.svh]
// register offsets, field positions, reset values and timing counts of the
// port power-down / interrupt pin logic; included by bare name
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH

// management register offsets (5-bit register address)
`define PPI_OFS_BASIC_MODE_CONTROL 5'h00
`define PPI_OFS_INTERRUPT_CONTROL 5'h11
`define PPI_OFS_INTERRUPT_STATUS_AND_MASK 5'h12
`define PPI_OFS_ENERGY_SENSE_CONTROL 5'h1D

// basic mode control fields
`define PPI_BMC_POWER_DOWN_BIT 11

// interrupt control fields
`define PPI_ICTL_OUTPUT_SELECT_BIT 0
`define PPI_ICTL_IRQ_GLOBAL_ENABLE_BIT 1
`define PPI_ICTL_USED_MASK 16'h0003

// status/mask layout: enables in [7:0], pending flags in [15:8]
`define PPI_SRC_LINK_CHANGE 5
`define PPI_SRC_ENERGY_CHANGE 6

// energy sense control fields
`define PPI_ESC_ENABLE_BIT 15
`define PPI_ESC_LOW_POWER_BIT 0
`define PPI_ESC_TX_WAKE_BIT 1
`define PPI_ESC_WRITE_MASK 16'h8000

// reset values
`define PPI_RST_BASIC_MODE_CONTROL 16'h0000
`define PPI_RST_INTERRUPT_CONTROL 16'h0000
`define PPI_RST_IRQ_ENABLES 8'h00
`define PPI_RST_ENERGY_SENSE_CONTROL 16'h0000

// timing, in the clock period and in nanoseconds
`define PPI_CLK_PERIOD_NS 10
`define PPI_ED_QUIET_NS 1000000
`define PPI_ED_PULSE_PERIOD_NS 1000000
`define PPI_ED_PULSE_WIDTH_NS 100
`define PPI_ED_WAKE_NS 10000
// least times round up, none below one cycle
`define PPI_ED_QUIET_CYC ((`PPI_ED_QUIET_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS)
`define PPI_ED_PULSE_PERIOD_CYC \
  ((`PPI_ED_PULSE_PERIOD_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS)
`define PPI_ED_PULSE_WIDTH_CYC \
  ((`PPI_ED_PULSE_WIDTH_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS)
`define PPI_ED_WAKE_CYC ((`PPI_ED_WAKE_NS + `PPI_CLK_PERIOD_NS - 1) / `PPI_CLK_PERIOD_NS)

`endif

// [rtl/ppi_pkg.sv]
// types shared by the port power-down / interrupt pin logic
// assumes nothing beyond a SystemVerilog compiler
package ppi_pkg;

  // energy-detect low-power sequencer states
  typedef enum logic [1:0] {
    PPI_ED_ACTIVE = 2'b00, // normal operation, watching for a quiet line
    PPI_ED_SLEEP = 2'b01,  // low power, monitoring the line
    PPI_ED_PULSE = 2'b10,  // transmitter briefly woken for a pulse
    PPI_ED_WAKE = 2'b11    // normal power-up sequence running
  } ppi_ed_state_t;

  typedef logic [15:0] ppi_word_t; // one management register
  typedef logic [4:0] ppi_addr_t;  // management register address

endpackage

// [rtl/ppi_sync2.sv]
// two-flip-flop synchroniser for levels arriving from outside the clock
// assumes a synchronous active-low reset and a constant reset level
`timescale 1ns/1ps
module ppi_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q; // first stage, read only by the second

  // both stages reset to a constant; only the second stage looks at meta_q
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [rtl/ppi_port.sv]
// one port's shared power-down / interrupt pin logic with its management
// registers and the energy-detect low-power sequencer
// assumes register strobes from the management interface on CLK_SYS, an
// external weak pull-up on the pin, and one instance per port
//
// Summary of operation
// R1: after reset pin is power-down input
// R2: output-select bit makes pin active-low interrupt
// R3: each port has its own pin
// R4: pin low as input means port power-down
// R5: pulled-low pin gives power-down from initialisation
// R6: registers work while down; output-select releases
// R7: wired-OR host checks every port's status
// R8: all interrupt sources masked after reset
// R9: pin signals only with global enable and mask
// R10: enabled event drives pin low immediately; here the pin falls at the edge that latches the event
// R11: upper status byte shows pending sources
// R12: status read clears all pending flags
// R13: host writes 0003h to interrupt control
// R14: 0060h enables link and energy-change interrupts
// R15: quiet line keeps low power; activity powers up
// R16: low power periodically wakes transmitter for pulses
// R17: energy sense control register at 1Dh
// R18: pending flag stays until status read
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_port #(
  parameter int QUIET_CYC = `PPI_ED_QUIET_CYC,             // quiet time before sleep
  parameter int PULSE_PERIOD_CYC = `PPI_ED_PULSE_PERIOD_CYC, // spacing of wake pulses
  parameter int PULSE_WIDTH_CYC = `PPI_ED_PULSE_WIDTH_CYC,   // length of a wake pulse
  parameter int WAKE_CYC = `PPI_ED_WAKE_CYC                  // power-up sequence length
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire ppi_pkg::ppi_addr_t REG_ADDR,
  input wire ppi_pkg::ppi_word_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output ppi_pkg::ppi_word_t REG_RDATA,
  input wire logic SLEEP_OR_IRQ_PIN_I,
  output logic SLEEP_OR_IRQ_PIN_O,
  output logic SLEEP_OR_IRQ_PIN_OE,
  input wire logic LINK_STATUS,
  input wire logic LINE_ENERGY,
  input wire logic [7:0] OTHER_EVENTS,
  output logic POWER_DOWN,
  output logic LOW_POWER,
  output logic TX_WAKE
);
  import ppi_pkg::*;

  localparam int CNT_W = 32; // wide enough for every count parameter
  // energy enable reset level, taken from the full register reset word
  localparam ppi_word_t ESC_RST = `PPI_RST_ENERGY_SENSE_CONTROL;

  // register state
  ppi_word_t basic_mode_control_q;  // stored, bit 11 forces power-down
  ppi_word_t interrupt_control_q;   // output select and global enable
  logic [7:0] irq_enables_q;        // lower byte of status/mask
  logic [7:0] pending_q;            // upper byte of status/mask
  logic energy_sense_enable_q;      // energy-detect mode on
  // pin and line inputs after synchronisation
  logic pin_in_s;
  logic line_energy_s;
  // event detection
  logic link_status_q;              // last cycle's link level
  logic low_power_prev_q;           // last cycle's low-power state
  logic [7:0] events;               // one-cycle source events
  // energy-detect sequencer
  ppi_ed_state_t ed_state_q;
  logic [CNT_W-1:0] ed_cnt_q;       // quiet time while active, time in the pulse and wake states
  logic [CNT_W-1:0] pulse_cnt_q;    // time since the last wake pulse

  // true when the strobed address selects the given register
  function automatic logic hit(input ppi_addr_t a, input ppi_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // pin level into the clock domain; resets high like the idle pull-up
  // a strapped pin passes both stages before power-down may act on it
  ppi_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b1)
  ) u_pin_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .async_in(SLEEP_OR_IRQ_PIN_I),
    .sync_out(pin_in_s)
  );

  // analog energy sense is also asynchronous
  ppi_sync2 #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_energy_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .async_in(LINE_ENERGY),
    .sync_out(line_energy_s)
  );

  // basic mode control: plain storage, power-down bit feeds POWER_DOWN
  // other bits are stored for read-back only; they steer nothing here
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      basic_mode_control_q <= `PPI_RST_BASIC_MODE_CONTROL;
    end else if (REG_WR && hit(REG_ADDR, `PPI_OFS_BASIC_MODE_CONTROL)) begin
      basic_mode_control_q <= REG_WDATA;
    end
  end

  // interrupt control: cleared at reset so the pin starts as an input
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      interrupt_control_q <= `PPI_RST_INTERRUPT_CONTROL; // R1
    end else if (REG_WR && hit(REG_ADDR, `PPI_OFS_INTERRUPT_CONTROL)) begin
      // only output select and global enable exist; a 0003h write sets both
      interrupt_control_q <= REG_WDATA & `PPI_ICTL_USED_MASK; // R2 R13
    end
  end

  // source enables: lower byte of the status/mask register
  // pending bits in the upper byte are read-only; a write leaves them alone
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      irq_enables_q <= `PPI_RST_IRQ_ENABLES; // R8
    end else if (REG_WR && hit(REG_ADDR, `PPI_OFS_INTERRUPT_STATUS_AND_MASK)) begin
      // 0060h opens the link-change and energy-change sources
      irq_enables_q <= REG_WDATA[7:0]; // R14
    end
  end

  // energy sense control: enable is writable, state bits read back
  // the two status bits are not stored; reads show the live sequencer outputs
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      energy_sense_enable_q <= ESC_RST[`PPI_ESC_ENABLE_BIT];
    end else if (REG_WR && hit(REG_ADDR, `PPI_OFS_ENERGY_SENSE_CONTROL)) begin
      energy_sense_enable_q <= REG_WDATA[`PPI_ESC_ENABLE_BIT]; // R17
    end
  end

  // edge memories for the change events
  // both memories reset to the idle level of their source, so reset itself
  // raises no false change event
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      link_status_q <= 1'b0;
      low_power_prev_q <= 1'b0;
    end else begin
      link_status_q <= LINK_STATUS;
      low_power_prev_q <= LOW_POWER;
    end
  end

  // collect one-cycle events; link and energy changes join the other sources
  always_comb begin
    events = OTHER_EVENTS;
    events[`PPI_SRC_LINK_CHANGE] = OTHER_EVENTS[`PPI_SRC_LINK_CHANGE] |
                                   (LINK_STATUS ^ link_status_q);
    events[`PPI_SRC_ENERGY_CHANGE] = OTHER_EVENTS[`PPI_SRC_ENERGY_CHANGE] |
                                     (LOW_POWER ^ low_power_prev_q);
  end

  // pending flags: sticky, set only for enabled sources, cleared by a read;
  // a new event in the clearing cycle is kept, so no event is lost
  // a masked source never latches, so enabling it later raises no stale flag
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pending_q <= 8'h00;
    end else if (REG_RD && hit(REG_ADDR, `PPI_OFS_INTERRUPT_STATUS_AND_MASK)) begin
      pending_q <= events & irq_enables_q; // R12
    end else begin
      pending_q <= pending_q | (events & irq_enables_q); // R9 R18
    end
  end

  // read data: registered, one cycle after the read strobe
  // a status read returns the flags as they stood before the clearing edge
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      // management reads keep working while the port is powered down
      if (hit(REG_ADDR, `PPI_OFS_BASIC_MODE_CONTROL)) begin
        REG_RDATA <= basic_mode_control_q; // R6
      end else if (hit(REG_ADDR, `PPI_OFS_INTERRUPT_CONTROL)) begin
        REG_RDATA <= interrupt_control_q;
      end else if (hit(REG_ADDR, `PPI_OFS_INTERRUPT_STATUS_AND_MASK)) begin
        REG_RDATA <= {pending_q, irq_enables_q}; // R11
      end else if (hit(REG_ADDR, `PPI_OFS_ENERGY_SENSE_CONTROL)) begin
        REG_RDATA <= {energy_sense_enable_q, 13'h0000, TX_WAKE, LOW_POWER};
      end else begin
        REG_RDATA <= 16'h0000; // unmapped addresses read as zero
      end
    end
  end

  // pin driver: an input until output select; then active low interrupt.
  // the flag set and the pin fall share one edge, the fastest a registered
  // output allows; the wired-OR partner port has its own instance
  // limitation: the pin falls at the edge that latches the event, not
  // combinationally; a combinational path would break the registered outputs
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      SLEEP_OR_IRQ_PIN_OE <= 1'b0; // R1
      SLEEP_OR_IRQ_PIN_O <= 1'b1;
    end else begin
      SLEEP_OR_IRQ_PIN_OE <= interrupt_control_q[`PPI_ICTL_OUTPUT_SELECT_BIT]; // R2 R3
      SLEEP_OR_IRQ_PIN_O <= ~(interrupt_control_q[`PPI_ICTL_IRQ_GLOBAL_ENABLE_BIT] &
                              (|(pending_q | (events & irq_enables_q)))); // R9 R10
    end
  end

  // power-down: register bit or the pin held low while it is an input.
  // the synchroniser resets high, so a strapped-low pin takes effect three
  // edges after reset release, before any link activity can start
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      POWER_DOWN <= 1'b0;
    end else begin
      POWER_DOWN <= basic_mode_control_q[`PPI_BMC_POWER_DOWN_BIT] |
                    (~interrupt_control_q[`PPI_ICTL_OUTPUT_SELECT_BIT] & ~pin_in_s); // R4 R5 R6
    end
  end

  // energy-detect sequencer: sleep on a quiet line, pulse periodically,
  // run a power-up sequence on activity
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ed_state_q <= PPI_ED_ACTIVE;
      ed_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end else if (!energy_sense_enable_q || POWER_DOWN) begin
      // mode off or port forced down: sequencer parked
      ed_state_q <= PPI_ED_ACTIVE;
      ed_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end else begin
      case (ed_state_q)
        PPI_ED_ACTIVE: begin
          // count quiet cycles; any energy restarts the count
          if (line_energy_s) begin
            ed_cnt_q <= '0;
          end else if (ed_cnt_q >= CNT_W'(QUIET_CYC - 1)) begin
            ed_state_q <= PPI_ED_SLEEP; // R15
            ed_cnt_q <= '0;
            pulse_cnt_q <= '0;
          end else begin
            ed_cnt_q <= ed_cnt_q + 1'b1;
          end
        end
        PPI_ED_SLEEP: begin
          if (line_energy_s) begin
            ed_state_q <= PPI_ED_WAKE; // R15
            ed_cnt_q <= '0;
          end else if (pulse_cnt_q >= CNT_W'(PULSE_PERIOD_CYC - 1)) begin
            ed_state_q <= PPI_ED_PULSE; // R16
            ed_cnt_q <= '0;
            pulse_cnt_q <= '0;
          end else begin
            pulse_cnt_q <= pulse_cnt_q + 1'b1;
          end
        end
        PPI_ED_PULSE: begin
          // the pulse runs out whatever the line does
          if (ed_cnt_q >= CNT_W'(PULSE_WIDTH_CYC - 1)) begin
            ed_state_q <= line_energy_s ? PPI_ED_WAKE : PPI_ED_SLEEP; // R16
            ed_cnt_q <= '0;
          end else begin
            ed_cnt_q <= ed_cnt_q + 1'b1;
          end
        end
        PPI_ED_WAKE: begin
          if (ed_cnt_q >= CNT_W'(WAKE_CYC - 1)) begin
            ed_state_q <= PPI_ED_ACTIVE;
            ed_cnt_q <= '0;
          end else begin
            ed_cnt_q <= ed_cnt_q + 1'b1;
          end
        end
        // unused codes cannot occur; fall back to active if one ever does
        default: begin
          ed_state_q <= PPI_ED_ACTIVE;
          ed_cnt_q <= '0;
        end
      endcase
    end
  end

  // sequencer outputs registered from the state; LOW_POWER flips feed the
  // energy-change interrupt source
  // registering both costs a cycle of lag behind the state but keeps the
  // outputs free of decode glitches for the power switches they steer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      LOW_POWER <= 1'b0;
      TX_WAKE <= 1'b0;
    end else begin
      LOW_POWER <= (ed_state_q == PPI_ED_SLEEP) || (ed_state_q == PPI_ED_PULSE); // R15
      TX_WAKE <= (ed_state_q == PPI_ED_PULSE); // R16
    end
  end

endmodule

// [bench/ppi_port_props.sv]
// checker for one port's power-down / interrupt pin logic
// assumes it is bound to ppi_port and sees only its ports
`timescale 1ns/1ps
module ppi_port_props
  import ppi_pkg::*;
#(
  parameter int PULSE_WIDTH_CYC = 3 // wake pulse length in cycles
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire ppi_pkg::ppi_addr_t REG_ADDR,
  input wire ppi_pkg::ppi_word_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire ppi_pkg::ppi_word_t REG_RDATA,
  input wire logic SLEEP_OR_IRQ_PIN_I,
  input wire logic SLEEP_OR_IRQ_PIN_O,
  input wire logic SLEEP_OR_IRQ_PIN_OE,
  input wire logic LINK_STATUS,
  input wire logic LINE_ENERGY,
  input wire logic [7:0] OTHER_EVENTS,
  input wire logic POWER_DOWN,
  input wire logic LOW_POWER,
  input wire logic TX_WAKE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  // length of the current wake pulse; a counter keeps the figure a parameter
  logic [7:0] run_q;
  always_ff @(posedge CLK_SYS) begin
    run_q <= (!NRST || !TX_WAKE) ? 8'h00 : run_q + 8'h01;
  end

  // control write not overwritten in the next cycle
  sequence s_ctl_wr;
    REG_WR && REG_ADDR == 5'h11 ##1 !(REG_WR && REG_ADDR == 5'h11);
  endsequence
  // status read with no new event and no write around it
  sequence s_rd_clr;
    REG_RD && REG_ADDR == 5'h12 && !REG_WR && OTHER_EVENTS == 8'h00 &&
      $stable(LINK_STATUS) && $stable(LOW_POWER) ##1
    !REG_WR && OTHER_EVENTS == 8'h00 && $stable(LINK_STATUS) && $stable(LOW_POWER);
  endsequence

  property p_rst;
    $rose(NRST) |-> !SLEEP_OR_IRQ_PIN_OE && SLEEP_OR_IRQ_PIN_O && !POWER_DOWN &&
      !LOW_POWER && !TX_WAKE && REG_RDATA == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset values");
  property p_oe;
    s_ctl_wr |=> SLEEP_OR_IRQ_PIN_OE == $past(REG_WDATA[0], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not following select");
  property p_pd;
    (!SLEEP_OR_IRQ_PIN_I && !SLEEP_OR_IRQ_PIN_OE) [*4] |-> POWER_DOWN;
  endproperty
  a_pd: assert property (p_pd) else $error("low input pin gave no power-down");
  property p_hold;
    !SLEEP_OR_IRQ_PIN_O && !REG_WR && !$past(REG_WR) && !(REG_RD && REG_ADDR == 5'h12) &&
      !$past(REG_RD && REG_ADDR == 5'h12) |=> !SLEEP_OR_IRQ_PIN_O;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped without read");
  property p_clear;
    s_rd_clr |=> SLEEP_OR_IRQ_PIN_O;
  endproperty
  a_clear: assert property (p_clear) else $error("pin still low after read");
  property p_stand;
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_stand: assert property (p_stand) else $error("read data changed unread");
  property p_unm;
    REG_RD && !(REG_ADDR inside {5'h00, 5'h11, 5'h12, 5'h1D}) |=> REG_RDATA == 16'h0000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_tx;
    TX_WAKE |-> LOW_POWER;
  endproperty
  a_tx: assert property (p_tx) else $error("wake pulse outside low power");
  property p_width;
    $fell(TX_WAKE) && LOW_POWER |-> run_q == PULSE_WIDTH_CYC;
  endproperty
  a_width: assert property (p_width) else $error("wake pulse length wrong");
  property p_lp;
    POWER_DOWN [*3] |-> !LOW_POWER;
  endproperty
  a_lp: assert property (p_lp) else $error("low power kept while down");
endmodule

bind ppi_port ppi_port_props #(.PULSE_WIDTH_CYC(PULSE_WIDTH_CYC)) u_props (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .SLEEP_OR_IRQ_PIN_I(SLEEP_OR_IRQ_PIN_I), .SLEEP_OR_IRQ_PIN_O(SLEEP_OR_IRQ_PIN_O),
  .SLEEP_OR_IRQ_PIN_OE(SLEEP_OR_IRQ_PIN_OE), .LINK_STATUS(LINK_STATUS),
  .LINE_ENERGY(LINE_ENERGY), .OTHER_EVENTS(OTHER_EVENTS), .POWER_DOWN(POWER_DOWN),
  .LOW_POWER(LOW_POWER), .TX_WAKE(TX_WAKE));

// [bench/ppi_pin_host.sv]
// host side of the shared pin: external pull-down switch and weak pull-up
// assumes the block's output enable is high only while it drives
`timescale 1ns/1ps
module ppi_pin_host (
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pull_low,
  output logic pin_level
);
  // the block wins while driving; else the pull-down, else the pull-up
  assign pin_level = pin_oe ? pin_o : !pull_low;
endmodule

// [bench/port_powerdown_irq_pin_logic_tb.sv]
// self-checking bench for one port's power-down / interrupt pin logic
// assumes ppi_port, its package and the pin host model are compiled first
`timescale 1ns/1ps
module port_powerdown_irq_pin_logic_tb;
  import ppi_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  ppi_addr_t reg_addr = 5'h00;
  ppi_word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ppi_word_t reg_rdata;
  logic pin_i;
  logic pin_o;
  logic pin_oe;
  logic pull_low = 1'b0; // external pull-down fitted
  logic link_status = 1'b0;
  logic line_energy = 1'b0;
  logic [7:0] other_events = 8'h00;
  logic power_down;
  logic low_power;
  logic tx_wake;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h1499;
  ppi_word_t mask;
  ppi_word_t ev;
  ppi_word_t ctl;

  always #5 clk_sys = ~clk_sys;

  // short timing counts keep the energy-detect run brief
  ppi_port #(.QUIET_CYC(20), .PULSE_PERIOD_CYC(30), .PULSE_WIDTH_CYC(3), .WAKE_CYC(5)) uut (
    .CLK_SYS(clk_sys), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SLEEP_OR_IRQ_PIN_I(pin_i),
    .SLEEP_OR_IRQ_PIN_O(pin_o), .SLEEP_OR_IRQ_PIN_OE(pin_oe), .LINK_STATUS(link_status),
    .LINE_ENERGY(line_energy), .OTHER_EVENTS(other_events), .POWER_DOWN(power_down),
    .LOW_POWER(low_power), .TX_WAKE(tx_wake));
  ppi_pin_host u_pin (.pin_o(pin_o), .pin_oe(pin_oe), .pull_low(pull_low), .pin_level(pin_i));

  // status word: pending events of enabled sources above the enables
  function automatic ppi_word_t exp_status(input ppi_word_t e, input ppi_word_t m);
    return {e[7:0] & m[7:0], m[7:0]};
  endfunction
  // pin level: low only with global enable and something pending
  function automatic logic exp_pin(input ppi_word_t c, input ppi_word_t p);
    return !(c[1] && p[7:0] != 8'h00);
  endfunction

  task automatic check(input ppi_word_t seen, input ppi_word_t exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle strobes; the edge after the strobe's edge takes them
  task automatic wr(input ppi_addr_t a, input ppi_word_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input ppi_addr_t a, input ppi_word_t exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_sys);
    other_events <= e;
    @(posedge clk_sys);
    other_events <= 8'h00;
    #1;
  endtask
  task automatic done(input string name);
    $display("test %0s done", name);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(1);
    check(pin_oe, 16'h0000);
    check(pin_o, 16'h0001);
    check(power_down, 16'h0000);
    rd(5'h00, 16'h0000);
    rd(5'h11, 16'h0000);
    rd(5'h12, 16'h0000);
    wr(5'h1D, 16'h7FFF);
    rd(5'h1D, 16'h0000);
    wr(5'h11, 16'hFFFC);
    rd(5'h11, 16'h0000);
    // unmapped places swallow writes and read as zero
    for (int i = 0; i < 4; i++) begin
      mask = 16'(5'h13 + 5'($random(seed) & 7));
      wr(mask[4:0], 16'($random(seed)));
      rd(mask[4:0], 16'h0000);
    end
    done("reset");
    // second reset with the pin held low by the host
    @(posedge clk_sys);
    nrst <= 1'b0;
    pull_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(4);
    check(power_down, 16'h0001);
    wr(5'h12, 16'h0060);
    rd(5'h12, 16'h0060);
    wr(5'h11, 16'h0003);
    tick(2);
    check(power_down, 16'h0000);
    check(pin_oe, 16'h0001);
    check(pin_o, 16'h0001);
    pull_low <= 1'b0;
    wr(5'h00, 16'h0800);
    tick(2);
    check(power_down, 16'h0001);
    wr(5'h00, 16'h0000);
    tick(2);
    check(power_down, 16'h0000);
    done("pin");
    // random masks and events; one pass with the global enable off
    for (int i = 0; i < 6; i++) begin
      mask = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00FF : 16'($random(seed)) & 16'h00FF;
      ev = (16'($random(seed)) & 16'h00FF) | 16'h0001;
      ctl = (i == 2) ? 16'h0001 : 16'h0003;
      wr(5'h11, ctl);
      wr(5'h12, mask);
      pulse(ev[7:0]);
      check(pin_o, exp_pin(ctl, ev & mask));
      tick(4);
      check(pin_o, exp_pin(ctl, ev & mask));
      rd(5'h12, exp_status(ev, mask));
      tick(1);
      check(pin_o, 16'h0001);
    end
    wr(5'h12, 16'h0020);
    @(posedge clk_sys);
    link_status <= 1'b1;
    tick(1);
    check(pin_o, 16'h0000);
    rd(5'h12, 16'h2020);
    done("irq");
    // quiet line sleeps, pulses the transmitter, wakes on energy
    wr(5'h12, 16'h0040);
    wr(5'h1D, 16'h8000);
    repeat (60) if (low_power !== 1'b1) tick(1);
    check(low_power, 16'h0001);
    tick(1);
    check(pin_o, 16'h0000);
    rd(5'h1D, 16'h8001);
    repeat (60) if (tx_wake !== 1'b1) tick(1);
    check(tx_wake, 16'h0001);
    repeat (60) if (tx_wake !== 1'b0) tick(1);
    line_energy <= 1'b1;
    repeat (60) if (low_power !== 1'b0) tick(1);
    check(low_power, 16'h0000);
    tick(2);
    rd(5'h12, 16'h4040);
    done("energy");
    stop_test();
  end
endmodule
